/* temp_result_formatter_tb.sv */
// self-checking testbench of the temperature result formatter
`timescale 1ns/1ps
`default_nettype none
module temp_result_formatter_tb;
    import trf_pkg::*;
    logic       clk        = 1'b0;
    logic       srst       = 1'b1;
    logic [7:0] cfg        = 8'h00;
    logic       conv_start = 1'b0;
    trf_conv_t  conv       = '0;
    trf_word_t  local_word, remote_word, seen_local, seen_remote;
    trf_range_t range_used;
    logic       updated;
    int         err_total  = 0;
    int         checked    = 0;
    always #25 clk = ~clk;
    trf_formatter trf_formatter_i (.clk(clk), .srst(srst), .cfg(cfg), .conv_start(conv_start), .conv(conv),
        .local_word(local_word), .remote_word(remote_word), .range_used(range_used), .updated(updated));
    trf_host trf_host_i (.clk(clk), .updated(updated),
        .local_word(local_word), .remote_word(remote_word), .seen_local(seen_local), .seen_remote(seen_remote));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic convert(input logic remote, input logic [15:0] raw, input logic [15:0] exp);
        @(posedge clk) #1;
        conv = '{valid: 1'b1, remote: remote, raw: raw};
        @(posedge clk) #1;
        conv.valid = 1'b0;
        chk({15'h0000, updated}, 16'h0001);
        chk(remote ? remote_word : local_word, exp);
        @(posedge clk) #1;
        chk({15'h0000, updated}, 16'h0000);
        chk(remote ? seen_remote : seen_local, exp);
    endtask : convert
    task automatic start(input logic ext);
        @(posedge clk) #1;
        cfg = {5'h1F, ext, 2'h3}; // other bits set, must be ignored
        conv_start = 1'b1;
        @(posedge clk) #1;
        conv_start = 1'b0;
        chk({15'h0000, range_used}, {15'h0000, ext});
    endtask : start
    task automatic t_reset;
        srst = 1'b1;
        repeat (10) @(posedge clk);
        #1 srst = 1'b0;
        chk(local_word | remote_word, 16'h0000);
        chk({15'h0000, range_used}, 16'h0000);
    endtask : t_reset
    task automatic t_std;
        logic [15:0] raw[9] = '{16'h0190, 16'h0197, 16'hFFF0, 16'hFFFF, 16'h07F0, 16'h0800,
                                16'h0123, 16'h0050, 16'h0C05};
        logic [15:0] exp[9] = '{16'h1900, 16'h1970, 16'h0000, 16'h0000, 16'h7F00, 16'h7FF0,
                                16'h1230, 16'h0500, 16'h7FF0};
        start(1'b0);
        for (int i = 0; i < 9; i++) begin
            convert(i[0], raw[i], exp[i]);
        end
    endtask : t_std
    task automatic t_range;
        @(posedge clk) #1;
        cfg = 8'h04; // no start pulse, so nothing may change yet
        repeat (2) @(posedge clk);
        #1 chk(remote_word, 16'h0500);
        chk({15'h0000, range_used}, 16'h0000);
        convert(1'b1, 16'h0190, 16'h1900);
    endtask : t_range
    task automatic t_ext;
        logic [15:0] raw[8] = '{16'h0190, 16'hFC00, 16'hFBF0, 16'h0BF0, 16'h0BFF, 16'h0C00, 16'hFFF8,
                                16'hFB00};
        logic [15:0] exp[8] = '{16'h5900, 16'h0000, 16'h0000, 16'hFF00, 16'hFFF0, 16'hFFF0, 16'h3F80,
                                16'h0000};
        start(1'b1);
        chk(local_word, 16'h7FF0);
        chk(remote_word, 16'h1900);
        for (int i = 0; i < 8; i++) begin
            convert(i[0], raw[i], exp[i]);
        end
    endtask : t_ext
    task automatic t_overlap;
        @(posedge clk) #1;
        cfg = 8'h00;
        conv_start = 1'b1;
        conv = '{valid: 1'b1, remote: 1'b1, raw: 16'h0198};
        @(posedge clk) #1;
        conv_start = 1'b0;
        conv.valid = 1'b0;
        chk(remote_word, 16'h5980);
        chk({15'h0000, range_used}, 16'h0000);
    endtask : t_overlap
    task automatic complete_run;
        if (err_total == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run
    initial begin
        t_reset();
        t_std();
        t_range();
        t_ext();
        t_overlap();
        t_reset(); // second reset in mid-run clears stored words
        complete_run();
    end
    // about 85 cycles expected, allow well over ten times that
    initial begin
        #100000;
        err_total++;
        complete_run();
    end
endmodule : temp_result_formatter_tb
`default_nettype wire

/* trf_defines.svh */
// constants of the temperature result formatter
`ifndef TRF_DEFINES_SVH
`define TRF_DEFINES_SVH

`define TRF_RAW_W        16
`define TRF_FRAC_BITS    4
`define TRF_STD_MAX_INT  8'h7F
`define TRF_STD_MIN_INT  8'h00
`define TRF_EXT_OFFSET   8'h40
`define TRF_EXT_MAX_ENC  8'hFF
`define TRF_EXT_MIN_ENC  8'h00
`define TRF_CFG_RANGE_BIT 2
`define TRF_RESULT_RST   16'h0000
`define TRF_RANGE_RST    1'b0

`endif

/* trf_encode.sv */
// combinational encoder of one signed raw conversion into a stored word
`include "trf_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module trf_encode
    import trf_pkg::*;
#(
    parameter int RAW_W = `TRF_RAW_W
) (
    input  wire logic [RAW_W-1:0]    raw,   // signed, 1/16 degree per count
    input  wire trf_pkg::trf_range_t range, // range latched for this conversion
    output trf_pkg::trf_word_t       word   // formatted result
);
    import trf_pkg::*;

    if (RAW_W < 13 || RAW_W > 16) begin : g_raw_w_check
        $error("trf_encode: RAW_W must be 13..16");
    end

    logic signed [RAW_W-1:0] sraw;
    logic signed [RAW_W-5:0] ideg;
    logic signed [RAW_W-4:0] ext;

    always_comb begin
        sraw = signed'(raw);
        ideg = sraw[RAW_W-1:`TRF_FRAC_BITS];
        ext  = signed'({ideg[RAW_W-5], ideg}) + signed'((RAW_W-3)'(`TRF_EXT_OFFSET));
        word.frac_byte = {raw[`TRF_FRAC_BITS-1:0], 4'h0};
        if (range == TRF_RANGE_STD) begin
            if (sraw < 0) begin
                word.int_byte  = `TRF_STD_MIN_INT;
                word.frac_byte = 8'h00;
            end else if (ideg > signed'((RAW_W-4)'(`TRF_STD_MAX_INT))) begin
                word.int_byte  = `TRF_STD_MAX_INT;
                word.frac_byte = 8'hF0;
            end else begin
                word.int_byte = 8'(ideg);
            end
        end else begin
            if (ext < 0) begin
                word.int_byte  = `TRF_EXT_MIN_ENC;
                word.frac_byte = 8'h00;
            end else if (ext > signed'((RAW_W-3)'(`TRF_EXT_MAX_ENC))) begin
                word.int_byte  = `TRF_EXT_MAX_ENC;
                word.frac_byte = 8'hF0;
            end else begin
                word.int_byte = 8'(ext);
            end
        end
    end
endmodule : trf_encode
`default_nettype wire

/* trf_formatter.sv */
// temperature result formatter: local and remote result words
// Functional notes
// - each result carries 12 bits, one step being 0.0625 degree.
// - in the default range a temperature below zero stores integer zero.
// - in the default range a temperature above 127 stores integer 127.
// - configuration bit 2 low selects plain binary, high selects offset binary.
// - a range change leaves stored results alone and applies from the next conversion.
// - the extended range adds 64 to the integer value before storing.
// - the extended encoding spans minus 64 up to 191 degrees.
// - each result is two bytes, integer byte high and fraction byte low.
// - the fraction is left-justified in bits 7..4 with bits 3..0 zero.
`include "trf_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module trf_formatter
    import trf_pkg::*;
#(
    parameter int RAW_W = `TRF_RAW_W
) (
    input  wire logic               clk,         // 20 MHz system clock
    input  wire logic               srst,        // synchronous reset, active high
    input  wire logic [7:0]         cfg,         // configuration register image
    input  wire logic               conv_start,  // pulse: a conversion begins
    input  wire trf_pkg::trf_conv_t conv,        // finished conversion, one-cycle valid
    output trf_pkg::trf_word_t      local_word,  // stored local result
    output trf_pkg::trf_word_t      remote_word, // stored remote result
    output trf_pkg::trf_range_t     range_used,  // range of the conversion in flight
    output logic                    updated      // pulse after a result is stored
);
    import trf_pkg::*;

    if (RAW_W < 13 || RAW_W > 16) begin : g_raw_w_check
        $error("trf_formatter: RAW_W must be 13..16");
    end

    trf_word_t  enc_word;
    trf_word_t  next_local_word;
    trf_word_t  next_remote_word;
    trf_range_t next_range_used;
    logic       next_updated;

    // range sampled only at conversion start, so a mid-conversion write cannot mix formats
    always_comb begin
        next_range_used = range_used;
        if (conv_start) begin
            next_range_used = trf_range_t'(cfg[`TRF_CFG_RANGE_BIT]);
        end
    end

    trf_encode #(
        .RAW_W (RAW_W)
    ) u_encode (
        .raw   (conv.raw[RAW_W-1:0]),
        .range (range_used),
        .word  (enc_word)
    );

    always_comb begin
        next_local_word  = local_word;
        next_remote_word = remote_word;
        next_updated     = 1'b0;
        if (conv.valid) begin
            next_updated = 1'b1;
            if (conv.remote) begin
                next_remote_word = enc_word;
            end else begin
                next_local_word = enc_word;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            local_word  <= `TRF_RESULT_RST;
            remote_word <= `TRF_RESULT_RST;
            range_used  <= trf_range_t'(`TRF_RANGE_RST);
            updated     <= 1'b0;
        end else begin
            local_word  <= next_local_word;
            remote_word <= next_remote_word;
            range_used  <= next_range_used;
            updated     <= next_updated;
        end
    end

    // checks
    logic signed [RAW_W-1:0] sraw_chk;
    assign sraw_chk = signed'(conv.raw[RAW_W-1:0]);

    store_hold_a: assert property (@(posedge clk) disable iff (srst)
        !conv.valid |=> (local_word == $past(local_word) && remote_word == $past(remote_word)))
        else $error("stored result changed without a conversion");

    range_latch_a: assert property (@(posedge clk) disable iff (srst)
        conv_start |=> range_used == trf_range_t'($past(cfg[`TRF_CFG_RANGE_BIT])))
        else $error("range not taken from config bit at conversion start");

    range_steady_a: assert property (@(posedge clk) disable iff (srst)
        !conv_start |=> $stable(range_used))
        else $error("range changed between conversions");

    std_negative_a: assert property (@(posedge clk) disable iff (srst)
        conv.valid && !conv.remote && range_used == TRF_RANGE_STD && sraw_chk < 0
        |=> local_word.int_byte == 8'h00)
        else $error("negative value not clamped to zero");

    std_saturate_a: assert property (@(posedge clk) disable iff (srst)
        conv.valid && conv.remote && range_used == TRF_RANGE_STD && sraw_chk >= (128 <<< 4)
        |=> remote_word.int_byte == 8'h7F)
        else $error("hot value not saturated to 127");

    ext_offset_a: assert property (@(posedge clk) disable iff (srst)
        conv.valid && conv.remote && range_used == TRF_RANGE_EXT
        && sraw_chk >= -(64 <<< 4) && sraw_chk < (192 <<< 4)
        |=> remote_word.int_byte == 8'($past(sraw_chk) >>> 4) + 8'h40)
        else $error("extended offset wrong");

    ext_clamp_a: assert property (@(posedge clk) disable iff (srst)
        conv.valid && !conv.remote && range_used == TRF_RANGE_EXT && sraw_chk >= (192 <<< 4)
        |=> local_word.int_byte == 8'hFF)
        else $error("extended high clamp wrong");

    ext_low_a: assert property (@(posedge clk) disable iff (srst)
        conv.valid && !conv.remote && range_used == TRF_RANGE_EXT && sraw_chk < -(64 <<< 4)
        |=> local_word == 16'h0000)
        else $error("extended low clamp wrong");

    frac_justify_a: assert property (@(posedge clk) disable iff (srst)
        1'b1 |-> local_word.frac_byte[3:0] == 4'h0 && remote_word.frac_byte[3:0] == 4'h0)
        else $error("fraction low nibble not zero");

    frac_value_a: assert property (@(posedge clk) disable iff (srst)
        conv.valid && conv.remote && range_used == TRF_RANGE_STD
        && sraw_chk >= 0 && sraw_chk < (128 <<< 4)
        |=> remote_word.frac_byte[7:4] == $past(conv.raw[3:0]))
        else $error("fraction bits wrong");

    update_pulse_a: assert property (@(posedge clk) disable iff (srst)
        conv.valid |=> updated)
        else $error("update pulse missing");

    range_ext_sel_a: assert property (@(posedge clk) disable iff (srst)
        conv_start && cfg[`TRF_CFG_RANGE_BIT] |=> range_used == TRF_RANGE_EXT)
        else $error("config bit high did not select the extended range");

    std_neg_remote_a: assert property (@(posedge clk) disable iff (srst)
        conv.valid && conv.remote && range_used == TRF_RANGE_STD && sraw_chk < 0
        |=> remote_word == 16'h0000)
        else $error("negative remote value not stored as zero");

    std_sat_local_a: assert property (@(posedge clk) disable iff (srst)
        conv.valid && !conv.remote && range_used == TRF_RANGE_STD && sraw_chk >= (128 <<< 4)
        |=> local_word == 16'h7FF0)
        else $error("hot local value not saturated");

    std_plain_a: assert property (@(posedge clk) disable iff (srst)
        conv.valid && !conv.remote && range_used == TRF_RANGE_STD
        && sraw_chk >= 0 && sraw_chk < (128 <<< 4)
        |=> local_word.int_byte == 8'($past(sraw_chk) >>> 4))
        else $error("plain binary integer byte wrong");

    std_frac_local_a: assert property (@(posedge clk) disable iff (srst)
        conv.valid && !conv.remote && range_used == TRF_RANGE_STD
        && sraw_chk >= 0 && sraw_chk < (128 <<< 4)
        |=> local_word.frac_byte == {$past(conv.raw[3:0]), 4'h0})
        else $error("local fraction byte wrong");

    ext_offset_local_a: assert property (@(posedge clk) disable iff (srst)
        conv.valid && !conv.remote && range_used == TRF_RANGE_EXT
        && sraw_chk >= -(64 <<< 4) && sraw_chk < (192 <<< 4)
        |=> local_word.int_byte == 8'($past(sraw_chk) >>> 4) + 8'h40)
        else $error("local extended offset wrong");

    ext_frac_local_a: assert property (@(posedge clk) disable iff (srst)
        conv.valid && !conv.remote && range_used == TRF_RANGE_EXT
        && sraw_chk >= -(64 <<< 4) && sraw_chk < (192 <<< 4)
        |=> local_word.frac_byte == {$past(conv.raw[3:0]), 4'h0})
        else $error("local extended fraction wrong");

    ext_frac_remote_a: assert property (@(posedge clk) disable iff (srst)
        conv.valid && conv.remote && range_used == TRF_RANGE_EXT
        && sraw_chk >= -(64 <<< 4) && sraw_chk < (192 <<< 4)
        |=> remote_word.frac_byte == {$past(conv.raw[3:0]), 4'h0})
        else $error("remote extended fraction wrong");

    ext_high_remote_a: assert property (@(posedge clk) disable iff (srst)
        conv.valid && conv.remote && range_used == TRF_RANGE_EXT && sraw_chk >= (192 <<< 4)
        |=> remote_word == 16'hFFF0)
        else $error("remote extended high clamp wrong");

    ext_low_remote_a: assert property (@(posedge clk) disable iff (srst)
        conv.valid && conv.remote && range_used == TRF_RANGE_EXT && sraw_chk < -(64 <<< 4)
        |=> remote_word == 16'h0000)
        else $error("remote extended low clamp wrong");

    remote_only_a: assert property (@(posedge clk) disable iff (srst)
        conv.valid && conv.remote |=> local_word == $past(local_word))
        else $error("remote conversion disturbed the local word");

    local_only_a: assert property (@(posedge clk) disable iff (srst)
        conv.valid && !conv.remote |=> remote_word == $past(remote_word))
        else $error("local conversion disturbed the remote word");

    update_idle_a: assert property (@(posedge clk) disable iff (srst)
        !conv.valid |=> !updated)
        else $error("update pulse without a conversion");

    update_cause_a: assert property (@(posedge clk) disable iff (srst)
        updated |-> $past(conv.valid))
        else $error("update pulse not caused by a conversion");

    // no disable here: the reset itself is what is watched
    reset_clear_a: assert property (@(posedge clk)
        srst |=> local_word == 16'h0000 && remote_word == 16'h0000
        && range_used == TRF_RANGE_STD && !updated)
        else $error("reset did not clear the stored state");

    cov_std_c:  cover property (@(posedge clk) conv.valid && range_used == TRF_RANGE_STD);
    cov_ext_c:  cover property (@(posedge clk) conv.valid && range_used == TRF_RANGE_EXT);
    cov_swap_c: cover property (@(posedge clk) conv_start && cfg[`TRF_CFG_RANGE_BIT] != range_used);
    cov_neg_c:  cover property (@(posedge clk) conv.valid && sraw_chk < 0);
    cov_hot_c:  cover property (@(posedge clk) conv.valid && range_used == TRF_RANGE_EXT && sraw_chk >= (192 <<< 4));
endmodule : trf_formatter
`default_nettype wire

/* trf_host.sv */
// host model that copies stored results after each update
`timescale 1ns/1ps
`default_nettype none
module trf_host
    import trf_pkg::*;
(
    input  wire logic               clk,         // system clock
    input  wire logic               updated,     // result stored pulse
    input  wire trf_pkg::trf_word_t local_word,  // stored local result
    input  wire trf_pkg::trf_word_t remote_word, // stored remote result
    output var  trf_pkg::trf_word_t seen_local,  // host copy of local
    output var  trf_pkg::trf_word_t seen_remote  // host copy of remote
);
    import trf_pkg::*;

    // read only after the pulse, as the host would after a conversion
    always_ff @(posedge clk) begin
        if (updated) begin
            seen_local <= local_word;
            seen_remote <= remote_word;
        end
    end
endmodule : trf_host
`default_nettype wire

/* trf_pkg.sv */
// types of the temperature result formatter
package trf_pkg;
    typedef enum logic [0:0] {
        TRF_RANGE_STD = 1'b0,
        TRF_RANGE_EXT = 1'b1
    } trf_range_t;

    typedef struct packed {
        logic [7:0] int_byte;
        logic [7:0] frac_byte;
    } trf_word_t;

    typedef struct packed {
        logic        valid;
        logic        remote;
        logic [15:0] raw;
    } trf_conv_t;
endpackage : trf_pkg
